// *** design/tkci_top.sv ***
`timescale 1ns/1ps
`include "tkci_defs.svh"
module tkci_top
  import tkci_pkg::*;
#(
  parameter int unsigned ACQ_PERIOD_CYC = `TKCI_ACQ_PERIOD_CYC
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // acquisition side data
  input  wire tkci_keywr_s key_wr,
  input  wire logic [63:0] touched,
  input  wire logic [7:0]  checksum,
  input  wire logic [3:0]  dev_status,
  // external interference sync pin
  input  wire logic        ext_sync,
  // acquisition control
  output logic             noise_sync_active,
  output logic             acq_start
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check
  generate
    if (ACQ_PERIOD_CYC < 2) begin : g_bad_period
      $error("ACQ_PERIOD_CYC must be at least 2");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0]  kmem [0:447];
  tkci_state_e state_r;
  tkci_scope_e scope_mode_r;
  logic [5:0]  scope_idx_r;
  logic        scope_ok_r;
  logic        dir_put_r;
  logic        ns_stored_r;
  logic        ns_active_r;
  logic [7:0]  op_r;
  logic [5:0]  cnt_r;
  logic [7:0]  rsp_byte_r;
  logic        rsp_valid_r;
  logic        dp_wr_cmd_r;
  logic [31:0] hrdata_r;
  logic        sync_m_r;
  logic        sync_a_r;
  logic        sync_b_r;
  logic        sync_lvl_r;
  logic        sync_prev_r;
  logic [31:0] acq_cnt_r;
  logic        acq_start_r;
  logic        ap_take;
  logic        pop;
  logic        cmd_wr;
  logic [7:0]  cmd_byte;
  logic [7:0]  first_key;
  logic [5:0]  last_cnt;
  logic [31:0] stat_word;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // key index of the n-th key inside the scope
  function automatic logic [5:0] scope_key(input tkci_scope_e m, input logic [5:0] idx, input logic [5:0] n);
    case (m)
      TKCI_SC_ONE: scope_key = idx;
      TKCI_SC_ROW: scope_key = {idx[2:0], n[2:0]};
      TKCI_SC_COL: scope_key = {n[2:0], idx[2:0]};
      TKCI_SC_ALL: scope_key = n;
      default:     scope_key = idx;
    endcase
  endfunction : scope_key

  // data selector of a status opcode
  function automatic logic [2:0] op_sel(input logic [7:0] op);
    if (op == `TKCI_OP_ERR_ONE || op == `TKCI_OP_ERR_GRP)
      op_sel = `TKCI_SEL_ERR;
    else if (op == `TKCI_OP_TOUCH_GRP)
      op_sel = `TKCI_SEL_TOUCH;
    else
      op_sel = op[2:0];
  endfunction : op_sel

  // single key status opcode
  function automatic logic is_single(input logic [7:0] op);
    is_single = (op[7:4] == 4'h3 && op[3:0] <= 4'h5) || op == `TKCI_OP_ERR_ONE;
  endfunction : is_single

  // group status opcode
  function automatic logic is_group(input logic [7:0] op);
    is_group = (op[7:4] == 4'h2 && op[3:0] <= 4'h5) || op == `TKCI_OP_ERR_GRP || op == `TKCI_OP_TOUCH_GRP;
  endfunction : is_group

  // one status byte of one key
  function automatic logic [7:0] key_byte(input logic [2:0] sel, input logic [5:0] key);
    logic [7:0] v;
    v = 8'h00;
    case (sel)
      `TKCI_SEL_TOUCH: v = {7'h00, touched[key]};
      `TKCI_SEL_CAP: begin
        v = kmem[{sel, key}];
        if (v > `TKCI_CAP_MAX)
          v = `TKCI_CAP_MAX;
      end
      `TKCI_SEL_ERR: v = kmem[{sel, key}] & `TKCI_NIBBLE_MASK;
      default:       v = kmem[{sel, key}];
    endcase
    key_byte = v;
  endfunction : key_byte

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign ap_take  = hsel && hready && htrans[1];
  assign pop      = ap_take && !hwrite && haddr[7:0] == `TKCI_ADDR_RSP;
  assign cmd_wr   = dp_wr_cmd_r;
  assign cmd_byte = hwdata[7:0];
  assign last_cnt = (scope_mode_r == TKCI_SC_ALL) ? 6'd63 :
                    (scope_mode_r == TKCI_SC_ONE) ? 6'd0 : 6'd7;

  // status word
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`TKCI_ST_DIR] = dir_put_r;
    stat_word[`TKCI_ST_SCOPE_OK] = scope_ok_r;
    stat_word[`TKCI_ST_MODE_LO +: 2] = scope_mode_r;
    stat_word[`TKCI_ST_IDX_LO +: 6] = scope_idx_r;
    stat_word[`TKCI_ST_NS_STORED] = ns_stored_r;
    stat_word[`TKCI_ST_NS_ACTIVE] = ns_active_r;
    stat_word[`TKCI_ST_BUSY] = (state_r != TKCI_IDLE) || rsp_valid_r;
    stat_word[`TKCI_ST_RSP_VALID] = rsp_valid_r;
  end

  // lowest touched key, or no-touch code
  always_comb begin
    first_key = `TKCI_NO_TOUCH;
    for (int i = 63; i >= 0; i--) begin
      if (touched[i])
        first_key = 8'(i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait, read data registered in address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r    <= 32'h0000_0000;
      dp_wr_cmd_r <= 1'b0;
    end else begin
      dp_wr_cmd_r <= ap_take && hwrite && haddr[7:0] == `TKCI_ADDR_CMD;
      if (ap_take && !hwrite) begin
        case (haddr[7:0])
          `TKCI_ADDR_RSP:  hrdata_r <= {23'h00_0000, rsp_valid_r, rsp_byte_r};
          `TKCI_ADDR_STAT: hrdata_r <= stat_word;
          default:         hrdata_r <= 32'h0000_0000;
        endcase
      end else begin
        hrdata_r <= 32'h0000_0000;
      end
    end
  end

  // handshake outputs held in flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata = hrdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // key data memory written by acquisition
  always_ff @(posedge hclk) begin
    if (key_wr.we && key_wr.sel < `TKCI_SEL_TOUCH)
      kmem[{key_wr.sel, key_wr.key}] <= key_wr.data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // command interpreter and response byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r      <= TKCI_IDLE;
      scope_mode_r <= TKCI_SC_ONE;
      scope_idx_r  <= 6'h00;
      scope_ok_r   <= 1'b0;
      dir_put_r    <= `TKCI_DIR_RST;
      ns_stored_r  <= `TKCI_NSYNC_RST;
      ns_active_r  <= `TKCI_NSYNC_RST;
      op_r         <= 8'h00;
      cnt_r        <= 6'h00;
      rsp_byte_r   <= 8'h00;
      rsp_valid_r  <= 1'b0;
    end else begin
      if (pop)
        rsp_valid_r <= 1'b0;
      case (state_r)
        TKCI_IDLE: begin
          if (cmd_wr && !rsp_valid_r) begin
            case (cmd_byte)
              `TKCI_OP_GET, `TKCI_OP_PUT: begin
                dir_put_r   <= (cmd_byte == `TKCI_OP_PUT);
                rsp_byte_r  <= cmd_byte;
                rsp_valid_r <= 1'b1;
              end
              `TKCI_OP_SCOPE_ALL: begin
                scope_mode_r <= TKCI_SC_ALL;
                scope_ok_r   <= 1'b1;
                rsp_byte_r   <= cmd_byte;
                rsp_valid_r  <= 1'b1;
              end
              `TKCI_OP_SCOPE_ONE, `TKCI_OP_SCOPE_ROW, `TKCI_OP_SCOPE_COL: begin
                op_r    <= cmd_byte;
                state_r <= TKCI_OPND;
              end
              `TKCI_OP_NSYNC: begin
                if (dir_put_r) begin
                  op_r    <= cmd_byte;
                  state_r <= TKCI_OPND;
                end else begin
                  rsp_byte_r  <= {7'h00, ns_stored_r};
                  rsp_valid_r <= 1'b1;
                end
              end
              `TKCI_OP_RESET: begin
                ns_active_r <= ns_stored_r;
                dir_put_r   <= `TKCI_DIR_RST;
                rsp_byte_r  <= cmd_byte;
                rsp_valid_r <= 1'b1;
              end
              `TKCI_OP_CHKSUM: begin
                rsp_byte_r  <= checksum;
                rsp_valid_r <= 1'b1;
              end
              `TKCI_OP_GSTAT: begin
                rsp_byte_r  <= {4'h0, dev_status};
                rsp_valid_r <= 1'b1;
              end
              `TKCI_OP_FIRST: begin
                rsp_byte_r  <= first_key;
                rsp_valid_r <= 1'b1;
              end
              default: begin
                if (is_single(cmd_byte) && scope_ok_r) begin
                  rsp_byte_r  <= key_byte(op_sel(cmd_byte), scope_key(scope_mode_r, scope_idx_r, 6'h00));
                  rsp_valid_r <= 1'b1;
                end else if (is_group(cmd_byte) && scope_ok_r) begin
                  op_r    <= cmd_byte;
                  cnt_r   <= 6'h00;
                  state_r <= TKCI_STREAM;
                end
              end
            endcase
          end
        end
        TKCI_OPND: begin
          if (cmd_wr) begin
            state_r <= TKCI_IDLE;
            case (op_r)
              `TKCI_OP_SCOPE_ONE: begin
                if (cmd_byte <= `TKCI_KEY_MAX) begin
                  scope_mode_r <= TKCI_SC_ONE;
                  scope_idx_r  <= cmd_byte[5:0];
                  scope_ok_r   <= 1'b1;
                  rsp_byte_r   <= op_r;
                  rsp_valid_r  <= 1'b1;
                end
              end
              `TKCI_OP_SCOPE_ROW, `TKCI_OP_SCOPE_COL: begin
                if (cmd_byte <= `TKCI_LINE_MAX) begin
                  scope_mode_r <= (op_r == `TKCI_OP_SCOPE_ROW) ? TKCI_SC_ROW : TKCI_SC_COL;
                  scope_idx_r  <= cmd_byte[5:0];
                  scope_ok_r   <= 1'b1;
                  rsp_byte_r   <= op_r;
                  rsp_valid_r  <= 1'b1;
                end
              end
              `TKCI_OP_NSYNC: begin
                if (cmd_byte <= `TKCI_NSYNC_MAX && dir_put_r) begin
                  ns_stored_r <= cmd_byte[0];
                  rsp_byte_r  <= op_r;
                  rsp_valid_r <= 1'b1;
                end
              end
              default: ;
            endcase
          end
        end
        TKCI_STREAM: begin
          if (!rsp_valid_r) begin
            rsp_byte_r  <= key_byte(op_sel(op_r), scope_key(scope_mode_r, scope_idx_r, cnt_r));
            rsp_valid_r <= 1'b1;
            if (cnt_r == last_cnt)
              state_r <= TKCI_IDLE;
            else
              cnt_r <= cnt_r + 6'h01;
          end
        end
        default: state_r <= TKCI_IDLE;
      endcase
    end
  end

  assign noise_sync_active = ns_active_r;

  ////////////////////////////////////////////////////////////////////////////
  // external sync pin: three flops, level taken when last two agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_m_r    <= 1'b0;
      sync_a_r    <= 1'b0;
      sync_b_r    <= 1'b0;
      sync_lvl_r  <= 1'b0;
      sync_prev_r <= 1'b0;
    end else begin
      sync_m_r    <= ext_sync;
      sync_a_r    <= sync_m_r;
      sync_b_r    <= sync_a_r;
      if (sync_a_r == sync_b_r)
        sync_lvl_r <= sync_b_r;
      sync_prev_r <= sync_lvl_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acquisition start: locked to sync edge or free running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acq_cnt_r   <= 32'h0000_0000;
      acq_start_r <= 1'b0;
    end else if (ns_active_r) begin
      acq_cnt_r   <= 32'h0000_0000;
      acq_start_r <= sync_lvl_r && !sync_prev_r;
    end else if (acq_cnt_r == 32'(ACQ_PERIOD_CYC - 1)) begin
      acq_cnt_r   <= 32'h0000_0000;
      acq_start_r <= 1'b1;
    end else begin
      acq_cnt_r   <= acq_cnt_r + 32'h0000_0001;
      acq_start_r <= 1'b0;
    end
  end

  assign acq_start = acq_start_r;

endmodule : tkci_top

// *** design/tkci_defs.svh ***
`ifndef TKCI_DEFS_SVH
`define TKCI_DEFS_SVH

// register byte offsets (low address byte)
`define TKCI_ADDR_CMD        8'h00
`define TKCI_ADDR_RSP        8'h04
`define TKCI_ADDR_STAT       8'h08

// opcodes
`define TKCI_OP_NSYNC        8'h17
`define TKCI_OP_GET          8'h67
`define TKCI_OP_PUT          8'h70
`define TKCI_OP_RESET        8'h72
`define TKCI_OP_SCOPE_ONE    8'h73
`define TKCI_OP_SCOPE_ALL    8'h53
`define TKCI_OP_SCOPE_ROW    8'h78
`define TKCI_OP_SCOPE_COL    8'h79
`define TKCI_OP_CHKSUM       8'h36
`define TKCI_OP_GSTAT        8'h37
`define TKCI_OP_ERR_ONE      8'h65
`define TKCI_OP_ERR_GRP      8'h45
`define TKCI_OP_FIRST        8'h6B
`define TKCI_OP_TOUCH_GRP    8'h4B

// operand limits, data clamp and mask, no-touch code
`define TKCI_KEY_MAX         8'h3F
`define TKCI_LINE_MAX        8'h07
`define TKCI_NSYNC_MAX       8'h01
`define TKCI_CAP_MAX         8'h02
`define TKCI_NIBBLE_MASK     8'h0F
`define TKCI_NO_TOUCH        8'hFF

// key data selectors
`define TKCI_SEL_CAP         3'h4
`define TKCI_SEL_ERR         3'h6
`define TKCI_SEL_TOUCH       3'h7

// reset values
`define TKCI_NSYNC_RST       1'b0
`define TKCI_DIR_RST         1'b0

// status and response register field positions
`define TKCI_ST_DIR          0
`define TKCI_ST_SCOPE_OK     1
`define TKCI_ST_MODE_LO      2
`define TKCI_ST_IDX_LO       4
`define TKCI_ST_NS_STORED    10
`define TKCI_ST_NS_ACTIVE    11
`define TKCI_ST_BUSY         12
`define TKCI_ST_RSP_VALID    13
`define TKCI_RSP_VALID_BIT   8

// timing
`define TKCI_CLK_MHZ         200
`define TKCI_ACQ_PERIOD_US   300
`define TKCI_ACQ_PERIOD_CYC  (`TKCI_ACQ_PERIOD_US * `TKCI_CLK_MHZ)

`endif

// *** design/tkci_pkg.sv ***
package tkci_pkg;

  // interpreter states
  typedef enum logic [1:0] {
    TKCI_IDLE   = 2'b00,
    TKCI_OPND   = 2'b01,
    TKCI_STREAM = 2'b10
  } tkci_state_e;

  // key scope kinds
  typedef enum logic [1:0] {
    TKCI_SC_ONE = 2'b00,
    TKCI_SC_ROW = 2'b01,
    TKCI_SC_COL = 2'b10,
    TKCI_SC_ALL = 2'b11
  } tkci_scope_e;

  // acquisition side key data write
  typedef struct packed {
    logic       we;
    logic [5:0] key;
    logic [2:0] sel;
    logic [7:0] data;
  } tkci_keywr_s;

endpackage : tkci_pkg

// *** bench/tkci_sva.sv ***
`timescale 1ns/1ps
module tkci_sva
  import tkci_pkg::*;
#(
  parameter int unsigned ACQ_PERIOD_CYC = 16
) (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // acquisition
  input wire logic        ext_sync,
  input wire logic        noise_sync_active,
  input wire logic        acq_start
);
  logic        rd_dp_r;
  logic        wr_dp_r;
  logic [7:0]  addr_r;
  logic        rst_cmd_r;
  logic        ok_r;
  logic [31:0] cnt_r;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////
  // data phase tracking and soft reset command seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_dp_r   <= 1'b0;
      wr_dp_r   <= 1'b0;
      addr_r    <= 8'h00;
      rst_cmd_r <= 1'b0;
    end else begin
      rd_dp_r   <= hsel && hready && htrans[1] && !hwrite;
      wr_dp_r   <= hsel && hready && htrans[1] && hwrite;
      addr_r    <= haddr[7:0];
      rst_cmd_r <= wr_dp_r && addr_r == 8'h00 && hwdata[7:0] == 8'h72;
    end
  end

  // cycles since last start, valid only over unsynced intervals
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 32'h0000_0000;
      ok_r  <= 1'b0;
    end else begin
      cnt_r <= acq_start ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
      ok_r  <= acq_start ? !noise_sync_active : ok_r && !noise_sync_active;
    end
  end

  ////////////////////////////////////////////////////////////
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("slave stalled or answered an error");
  acq_pulse_a: assert property (acq_start |=> !acq_start)
    else $error("acquisition start longer than one cycle");
  sync_follow_a: assert property (acq_start && noise_sync_active && $past(noise_sync_active) |-> $past(ext_sync, 3))
    else $error("synced start without external edge");
  sync_start_a: assert property ($rose(ext_sync) && noise_sync_active |-> ##[2:8] acq_start)
    else $error("external edge gave no start");
  acq_period_a: assert property (acq_start && ok_r |-> cnt_r == ACQ_PERIOD_CYC - 1)
    else $error("free running start at wrong spacing");
  acq_gap_a: assert property (ok_r |-> cnt_r < ACQ_PERIOD_CYC)
    else $error("free running start missing");
  ns_hold_a: assert property ($changed(noise_sync_active) |-> rst_cmd_r || $past(rst_cmd_r))
    else $error("applied noise sync changed without soft reset");
  rd_idle_a: assert property (!rd_dp_r |-> hrdata == 32'h0000_0000)
    else $error("read data outside a read data phase");
  unmapped_a: assert property (rd_dp_r && addr_r != 8'h04 && addr_r != 8'h08 |-> hrdata == 32'h0000_0000)
    else $error("write only or unmapped place read nonzero");
  stat_active_a: assert property (rd_dp_r && addr_r == 8'h08 |-> hrdata[11] == $past(noise_sync_active))
    else $error("status shows wrong applied noise sync");
endmodule : tkci_sva

bind tkci_top tkci_sva #(.ACQ_PERIOD_CYC(ACQ_PERIOD_CYC)) tkci_sva_i (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .ext_sync, .noise_sync_active, .acq_start
);

// *** bench/tkci_host.sv ***
`timescale 1ns/1ps
module tkci_host (
  // clock
  input  wire logic        hclk,
  // ahb-lite master
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  // wait bound ran out
  output logic             hung
);
  // bus idle at time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h0000_0000;
    hung   = 1'b0;
  end

  ////////////////////////////////////////////////////////////
  // wait at rising edges for hready, under a bound
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (!hready && n < 64);
    if (!hready) hung <= 1'b1;
  endtask : wait_ready

  // single word transfer, then one idle cycle for the response to land
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata; // reads drive the inverted previous hwdata onto the bus
    wait_ready();
    @(posedge hclk);
  endtask : xfer
endmodule : tkci_host

// *** bench/tkci_top_tb.sv ***
`timescale 1ns/1ps
module tkci_top_tb
  import tkci_pkg::*;
;
  localparam int unsigned PERIOD = 16;
  typedef struct packed {logic [7:0] a; logic [31:0] v; logic [31:0] m;} tkci_exp_s;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        hung;
  tkci_keywr_s key_wr;
  logic [63:0] touched;
  logic [7:0]  checksum;
  logic [3:0]  dev_status;
  logic        ext_sync;
  logic        noise_sync_active;
  logic        acq_start;
  logic [7:0]  mem [64][7];
  logic [31:0] seed = 32'h0000_7423;
  logic [31:0] v;
  tkci_exp_s   expq[$];
  tkci_exp_s   e;
  logic        rd_pend = 1'b0;
  int          n_mismatch;
  int          n_tests;
  int          k;
  int          s;

  tkci_top #(.ACQ_PERIOD_CYC(PERIOD)) tkci_top_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .key_wr, .touched, .checksum, .dev_status, .ext_sync, .noise_sync_active, .acq_start
  );
  tkci_host tkci_host_i (
    .hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hung
  );

  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // expected byte of one key for one data selector
  function automatic logic [7:0] expv(input int key, input int sel);
    case (sel)
      4: return (mem[key][4] > 8'h02) ? 8'h02 : mem[key][4];
      6: return mem[key][6] & 8'h0F;
      7: return {7'h00, touched[key]};
      default: return mem[key][sel];
    endcase
  endfunction : expv

  task automatic chk(input logic [7:0] a, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] reg %h exp %h got %h", a, exp, got);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  task automatic cmd(input logic [7:0] b);
    tkci_host_i.xfer(1'b1, 8'h00, {24'h00_0000, b});
  endtask : cmd

  // note the expectation, then read
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hFFFF_FFFF);
    expq.push_back('{a, x & m, m});
    tkci_host_i.xfer(1'b0, a, 32'h0000_0000);
  endtask : rd

  // command byte and its response {valid, byte}; byte unchecked when invalid
  task automatic cr(input logic [7:0] b, input logic [8:0] r);
    cmd(b);
    rd(8'h04, {23'h00_0000, r}, r[8] ? 32'hFFFF_FFFF : 32'hFFFF_FF00);
  endtask : cr

  task automatic grp(input logic [7:0] op, input int sel, input int n, input int base, input int step);
    int i;
    cmd(op);
    for (i = 0; i < n; i++) rd(8'h04, {24'h00_0001, expv(base + i * step, sel)});
  endtask : grp

  ////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  initial begin
    repeat (100000) @(posedge hclk);
    n_mismatch++;
    end_of_test();
  end

  // watch read data phases and compare against the oldest note
  always @(posedge hclk) begin
    if (rd_pend) begin
      if (expq.size() == 0) begin
        n_mismatch++;
      end else begin
        e = expq.pop_front();
        chk(e.a, hrdata & e.m, e.v);
      end
    end
    rd_pend <= hresetn && hsel && hreadyout && htrans[1] && !hwrite;
    if (hung) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    hresetn = 1'b0;
    key_wr = '0;
    touched = 64'h0000_0000_0000_0000;
    checksum = 8'h00;
    dev_status = 4'h0;
    ext_sync = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h08, 32'h0000_0000);
    cr(8'h30, 9'h000);
    cr(8'h6B, 9'h1FF);
    cr(8'h17, 9'h100);
    cr(8'h01, 9'h000);
    rd(8'h08, 32'h0000_0000, 32'h0000_0401);
    cr(8'h70, 9'h170);
    cmd(8'h17);
    cr(8'h01, 9'h117);
    rd(8'h08, 32'h0000_0401, 32'h0000_0C01);
    cr(8'h72, 9'h172);
    rd(8'h08, 32'h0000_0C00, 32'h0000_0C01);
    cr(8'h17, 9'h101);
    // external edges drive acquisition while synced
    repeat (2) begin
      ext_sync <= 1'b1;
      repeat (12) @(posedge hclk);
      ext_sync <= 1'b0;
      repeat (12) @(posedge hclk);
    end
    cr(8'h70, 9'h170);
    cmd(8'h17);
    cr(8'h00, 9'h117);
    cr(8'h72, 9'h172);
    repeat (3 * PERIOD) @(posedge hclk);
    // out of range operands are dropped, scope stays undefined
    cmd(8'h73);
    cr(8'h40, 9'h000);
    cmd(8'h78);
    cr(8'h08, 9'h000);
    cmd(8'h79);
    cr(8'h08, 9'h000);
    rd(8'h08, 32'h0000_0000, 32'h0000_0002);
    // load key data from the acquisition side
    for (k = 0; k < 64; k++) begin
      for (s = 0; s < 7; s++) begin
        v = rnd();
        mem[k][s] = v[7:0];
        key_wr <= '{1'b1, 6'(k), 3'(s), v[7:0]};
        @(posedge hclk);
      end
    end
    key_wr <= '0;
    touched <= {rnd(), rnd()};
    v = rnd();
    checksum <= v[7:0];
    dev_status <= v[11:8];
    // one key scope
    k = int'(v[21:16]);
    cmd(8'h73);
    cr(8'(k), 9'h173);
    for (s = 0; s < 6; s++) cr(8'h30 + 8'(s), {1'b1, expv(k, s)});
    cr(8'h65, {1'b1, expv(k, 6)});
    grp(8'h45, 6, 1, k, 0);
    grp(8'h4B, 7, 1, k, 0);
    // row scope: single reads use the first key
    k = int'(v[26:24]);
    cmd(8'h78);
    cr(8'(k), 9'h178);
    cr(8'h30, {1'b1, expv(k * 8, 0)});
    for (s = 0; s < 6; s++) grp(8'h20 + 8'(s), s, 8, k * 8, 1);
    // column scope
    k = int'(v[30:28]);
    cmd(8'h79);
    cr(8'(k), 9'h179);
    grp(8'h45, 6, 8, k, 8);
    grp(8'h4B, 7, 8, k, 8);
    // all keys and global reads
    cr(8'h53, 9'h153);
    grp(8'h21, 1, 64, 0, 1);
    grp(8'h4B, 7, 64, 0, 1);
    cr(8'h36, {1'b1, checksum});
    cr(8'h37, {5'h10, dev_status});
    s = 255;
    for (k = 63; k >= 0; k--) begin
      if (touched[k]) s = k;
    end
    cr(8'h6B, {1'b1, 8'(s)});
    // a command while a response waits is dropped
    cmd(8'h67);
    cr(8'h70, 9'h167);
    rd(8'h04, 32'h0000_0000, 32'hFFFF_FF00);
    rd(8'h08, 32'h0000_0000, 32'h0000_2001);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000);
    // reset in mid run restores defaults
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h08, 32'h0000_0000);
    end_of_test();
  end
endmodule : tkci_top_tb
